// ===== common/clock_setup_pkg.sv
package clock_setup_pkg;
  // System clock rate and the range boundary of the lock loops
  localparam int CLK_SYS_MHZ = 100;
  localparam int HIGH_RANGE_MHZ = 60;
  localparam int HALVE_DIVISOR = 2;

  // Longest tolerated gap between sampled edges, in system cycles
  localparam int GAP_W = 8;
  localparam logic [GAP_W-1:0] HF_GAP_CYCLES =
    GAP_W'((CLK_SYS_MHZ + HIGH_RANGE_MHZ - 1) / HIGH_RANGE_MHZ);
  localparam logic [GAP_W-1:0] LF_GAP_CYCLES = 8'hFF;

  // Edges a loop must see in a row before it reports lock
  localparam int EDGE_W = 5;
  localparam logic [EDGE_W-1:0] LOCK_EDGES = 5'h10;

  // Heartbeat and LEDs
  localparam int HEARTBEAT_W = 26;
  localparam int LED_COUNT = 5;
  localparam int LED_HEARTBEAT = 4;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_HEARTBEAT = 4'h8;

  // Control fields
  localparam int CTRL_W = 5;
  localparam int CTRL_COMMON_BIT = 0;
  localparam int CTRL_SHARED_HI_BIT = 1;
  localparam int CTRL_INPUT_HI_BIT = 2;
  localparam int CTRL_OUTPUT_HI_BIT = 3;
  localparam int CTRL_HALVE_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h03;

  // Status fields
  localparam int STATUS_W = 6;
  localparam int STAT_SHARED_LOCK_BIT = 0;
  localparam int STAT_INPUT_LOCK_BIT = 1;
  localparam int STAT_OUTPUT_LOCK_BIT = 2;
  localparam int STAT_SHARED_VALID_BIT = 3;
  localparam int STAT_INPUT_VALID_BIT = 4;
  localparam int STAT_OUTPUT_VALID_BIT = 5;

  typedef enum logic [2:0] {
    LOOP_IDLE = 3'b001,
    LOOP_HUNT = 3'b010,
    LOOP_LOCKED = 3'b100
  } loop_state_t;
endpackage : clock_setup_pkg

// ===== rtl/fifo_clock_domain_setup.sv
`timescale 1ns/10ps
module fifo_clock_domain_setup
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire logic [clock_setup_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [clock_setup_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [clock_setup_pkg::DATA_W-1:0] reg_rdata_out,
  // Clock sources toward the top level
  output logic shared_clock_source_out,
  output logic input_clock_source_out,
  output logic output_clock_source_out,
  // Conditioned clocks returned from the top level
  input wire logic shared_fifo_clock_in,
  input wire logic input_fifo_clock_in,
  input wire logic output_fifo_clock_in,
  // Clock status
  output logic shared_clock_valid_out,
  output logic input_clock_valid_out,
  output logic output_clock_valid_out,
  // Resets for logic on the returned clocks
  output logic shared_fifo_reset_out,
  output logic input_fifo_reset_out,
  output logic output_fifo_reset_out,
  // Application reset and LEDs
  output logic app_reset_out,
  output logic [clock_setup_pkg::LED_COUNT-1:0] led_out
);
  import clock_setup_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // A returned clock counts only when its loop is locked and the mode uses it
  function automatic logic clock_ok(input logic locked, input logic enable);
    clock_ok = locked && enable;
  endfunction : clock_ok

  // Control and status state
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic restart_r;
  logic restart_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Clock generation
  logic halve_r;
  logic [HEARTBEAT_W-1:0] heartbeat_r;

  // Lock and validity
  logic shared_locked;
  logic input_locked;
  logic output_locked;
  logic shared_valid_r;
  logic input_valid_r;
  logic output_valid_r;
  logic shared_rst_r;
  logic input_rst_r;
  logic output_rst_r;

  // Control fields
  wire common_fifo_clock_select = ctrl_r[CTRL_COMMON_BIT];
  wire shared_clock_high_range = ctrl_r[CTRL_SHARED_HI_BIT];
  wire input_clock_high_range = ctrl_r[CTRL_INPUT_HI_BIT];
  wire output_clock_high_range = ctrl_r[CTRL_OUTPUT_HI_BIT];
  wire halve_oscillator_select = ctrl_r[CTRL_HALVE_BIT];

  // Register decode
  wire ctrl_hit = hit(reg_addr_in, OFF_CTRL);
  wire status_hit = hit(reg_addr_in, OFF_STATUS);
  wire heartbeat_hit = hit(reg_addr_in, OFF_HEARTBEAT);
  wire ctrl_write = reg_write_in && ctrl_hit;
  wire [CTRL_W-1:0] ctrl_written = reg_wdata_in[CTRL_W-1:0];
  // A setting change means the source frequency or path moves: loops must relock
  wire ctrl_changed = ctrl_write && (ctrl_written != ctrl_r);

  // Status word
  wire [STATUS_W-1:0] status_word = {
    output_valid_r,
    input_valid_r,
    shared_valid_r,
    output_locked,
    input_locked,
    shared_locked
  };

  // Only the loops that the mode uses run; the others sit idle
  wire shared_enable = common_fifo_clock_select && !restart_r;
  wire input_enable = !common_fifo_clock_select && !restart_r;
  wire output_enable = !common_fifo_clock_select && !restart_r;

  // Valid flag and FIFO reset come from one term, so they never disagree while reset_in is low
  wire shared_ok = clock_ok(shared_locked, shared_enable);
  wire input_ok = clock_ok(input_locked, input_enable);
  wire output_ok = clock_ok(output_locked, output_enable);

  // Clock source: oscillator itself or its halved copy
  wire fifo_source = halve_oscillator_select ? halve_r : clk_sys_in;

  // Combinational read mux; reads of unmapped offsets give zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_read_in) begin
      if (ctrl_hit) begin
        rdata_nxt = DATA_W'(ctrl_r);
      end else if (status_hit) begin
        rdata_nxt = DATA_W'(status_word);
      end else if (heartbeat_hit) begin
        rdata_nxt = DATA_W'(heartbeat_r);
      end
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    restart_nxt = 1'b0;
    if (ctrl_write) begin
      ctrl_nxt = ctrl_written;
      restart_nxt = ctrl_changed;
    end
  end

  // Registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctrl_r <= CTRL_RESET;
      restart_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      restart_r <= restart_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Divide by two of the system oscillator
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      halve_r <= 1'b0;
    end else begin
      halve_r <= ~halve_r;
    end
  end

  // Heartbeat: its top bit blinks LED 4 so a loaded design is visible
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      heartbeat_r <= '0;
    end else begin
      heartbeat_r <= heartbeat_r + HEARTBEAT_W'(1);
    end
  end

  // Lock loops, one per possible returned clock
  lock_loop shared_loop (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .enable_in(shared_enable),
    .high_range_in(shared_clock_high_range),
    .clock_in(shared_fifo_clock_in),
    .locked_out(shared_locked)
  );

  lock_loop input_loop (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .enable_in(input_enable),
    .high_range_in(input_clock_high_range),
    .clock_in(input_fifo_clock_in),
    .locked_out(input_locked)
  );

  lock_loop output_loop (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .enable_in(output_enable),
    .high_range_in(output_clock_high_range),
    .clock_in(output_fifo_clock_in),
    .locked_out(output_locked)
  );

  // Valid only when locked and used by the current mode
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      shared_valid_r <= 1'b0;
      input_valid_r <= 1'b0;
      output_valid_r <= 1'b0;
    end else begin
      shared_valid_r <= shared_ok;
      input_valid_r <= input_ok;
      output_valid_r <= output_ok;
    end
  end

  // FIFO logic resets held until its clock is valid
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      shared_rst_r <= 1'b1;
      input_rst_r <= 1'b1;
      output_rst_r <= 1'b1;
    end else begin
      shared_rst_r <= !shared_ok;
      input_rst_r <= !input_ok;
      output_rst_r <= !output_ok;
    end
  end

  // Sources: only the paths of the current mode carry a clock
  assign shared_clock_source_out = common_fifo_clock_select & fifo_source;
  assign input_clock_source_out = !common_fifo_clock_select & fifo_source;
  assign output_clock_source_out = !common_fifo_clock_select & fifo_source;

  assign shared_clock_valid_out = shared_valid_r;
  assign input_clock_valid_out = input_valid_r;
  assign output_clock_valid_out = output_valid_r;

  // Reset reaches the FIFO logic at once, release waits for lock
  assign shared_fifo_reset_out = reset_in | shared_rst_r;
  assign input_fifo_reset_out = reset_in | input_rst_r;
  assign output_fifo_reset_out = reset_in | output_rst_r;

  // Passed with no clock in the way, so the application sees it asynchronously
  assign app_reset_out = reset_in;

  // LEDs 0..2 show valid clocks, LED 3 stays dark
  assign led_out = {
    heartbeat_r[HEARTBEAT_W-1],
    1'b0,
    output_valid_r,
    input_valid_r,
    shared_valid_r
  };

  assign reg_rdata_out = rdata_r;
endmodule : fifo_clock_domain_setup

// ===== rtl/lock_loop.sv
`timescale 1ns/10ps
module lock_loop
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Control
  input wire logic enable_in,
  input wire logic high_range_in,
  // Returned clock pin
  input wire logic clock_in,
  // Status
  output logic locked_out
);
  import clock_setup_pkg::*;

  logic clk_meta_r;
  logic clk_sync_r;
  logic clk_prev_r;
  logic [GAP_W-1:0] gap_r;
  logic [GAP_W-1:0] gap_nxt;
  logic [EDGE_W-1:0] edges_r;
  logic [EDGE_W-1:0] edges_nxt;
  loop_state_t state_r;
  loop_state_t state_nxt;

  wire edge_seen = clk_sync_r ^ clk_prev_r;
  // The high range loop tolerates only short gaps: sampled edges more than three cycles apart never lock it
  wire [GAP_W-1:0] gap_limit = high_range_in ? HF_GAP_CYCLES : LF_GAP_CYCLES;
  wire gap_over = (gap_r >= gap_limit) && !edge_seen;
  wire edges_done = edge_seen && (edges_r == LOCK_EDGES - 5'h01);

  // Pin passes two flops before anything looks at it; cleared with the loop so
  // that a stale or unknown sample cannot read as an edge right after reset
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      clk_meta_r <= 1'b0;
      clk_sync_r <= 1'b0;
      clk_prev_r <= 1'b0;
    end else begin
      clk_meta_r <= clock_in;
      clk_sync_r <= clk_meta_r;
      clk_prev_r <= clk_sync_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    gap_nxt = edge_seen ? '0 : (gap_over ? gap_r : gap_r + 8'h01);
    edges_nxt = edges_r;
    unique case (state_r)
      LOOP_IDLE: begin
        edges_nxt = '0;
        if (enable_in) begin
          state_nxt = LOOP_HUNT;
        end
      end
      LOOP_HUNT: begin
        if (gap_over) begin
          edges_nxt = '0;
        end else if (edges_done) begin
          state_nxt = LOOP_LOCKED;
        end else if (edge_seen) begin
          edges_nxt = edges_r + 5'h01;
        end
      end
      LOOP_LOCKED: begin
        if (gap_over) begin
          state_nxt = LOOP_HUNT;
          edges_nxt = '0;
        end
      end
      default: begin
        state_nxt = LOOP_IDLE;
      end
    endcase
    if (!enable_in) begin
      state_nxt = LOOP_IDLE;
      gap_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= LOOP_IDLE;
      gap_r <= '0;
      edges_r <= '0;
    end else begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
      edges_r <= edges_nxt;
    end
  end

  assign locked_out = (state_r == LOOP_LOCKED);
endmodule : lock_loop

// ===== tb/clock_return_model.sv
`timescale 1ns/10ps
module clock_return_model
(
  // Sources from the block
  input wire logic shared_src_in,
  input wire logic input_src_in,
  input wire logic output_src_in,
  // Bench control
  input wire logic [2:0] stall_in,
  // Conditioned clocks back
  output logic shared_clk_out,
  output logic input_clk_out,
  output logic output_clk_out
);
  // Loop phase shift; a stalled path stands low like a loop that lost its input
  assign #2 shared_clk_out = shared_src_in && !stall_in[0];
  assign #2 input_clk_out = input_src_in && !stall_in[1];
  assign #2 output_clk_out = output_src_in && !stall_in[2];
endmodule : clock_return_model

// ===== tb/clock_setup_monitor.sv
`timescale 1ns/10ps
module clock_setup_monitor
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Watched outputs
  input wire logic shared_clock_source_out,
  input wire logic input_clock_source_out,
  input wire logic output_clock_source_out,
  input wire logic shared_clock_valid_out,
  input wire logic input_clock_valid_out,
  input wire logic output_clock_valid_out,
  input wire logic shared_fifo_reset_out,
  input wire logic input_fifo_reset_out,
  input wire logic output_fifo_reset_out,
  input wire logic app_reset_out,
  input wire logic [clock_setup_pkg::LED_COUNT-1:0] led_out
);
  import clock_setup_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  app_reset_a: assert property (app_reset_out == reset_in)
    else $error("app reset differs");
  reset_clears_a: assert property (reset_in |=> shared_fifo_reset_out &&
    input_fifo_reset_out && output_fifo_reset_out && !led_out[LED_HEARTBEAT] &&
    !shared_clock_valid_out && !input_clock_valid_out && !output_clock_valid_out)
    else $error("reset left state");
  led_status_a: assert property (disable iff (reset_in) !led_out[3] &&
    led_out[2:0] == {output_clock_valid_out, input_clock_valid_out, shared_clock_valid_out})
    else $error("status leds wrong");
  valid_reset_a: assert property (disable iff (reset_in)
    !(shared_clock_valid_out && shared_fifo_reset_out) &&
    !(input_clock_valid_out && input_fifo_reset_out) &&
    !(output_clock_valid_out && output_fifo_reset_out))
    else $error("valid clock held in reset");
  domain_excl_a: assert property (disable iff (reset_in)
    !(shared_clock_valid_out && (input_clock_valid_out || output_clock_valid_out)))
    else $error("both domains valid");
  // Valid flags trail a mode change by one cycle, so the source is checked a cycle back
  shared_idle_a: assert property (disable iff (reset_in)
    (input_clock_valid_out || output_clock_valid_out) [*6] |-> !$past(shared_clock_source_out))
    else $error("shared source runs");
  sep_idle_a: assert property (disable iff (reset_in)
    shared_clock_valid_out [*6] |-> !$past(input_clock_source_out || output_clock_source_out))
    else $error("separate source runs");
  lock_delay_a: assert property (disable iff (reset_in)
    $rose(shared_clock_valid_out || input_clock_valid_out || output_clock_valid_out)
    |-> !$past(reset_in, 16))
    else $error("valid too soon");
endmodule : clock_setup_monitor

bind fifo_clock_domain_setup clock_setup_monitor i_clock_setup_monitor (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .app_reset_out(app_reset_out),
  .shared_clock_source_out(shared_clock_source_out), .led_out(led_out),
  .input_clock_source_out(input_clock_source_out),
  .output_clock_source_out(output_clock_source_out),
  .shared_clock_valid_out(shared_clock_valid_out),
  .input_clock_valid_out(input_clock_valid_out),
  .output_clock_valid_out(output_clock_valid_out),
  .shared_fifo_reset_out(shared_fifo_reset_out),
  .input_fifo_reset_out(input_fifo_reset_out),
  .output_fifo_reset_out(output_fifo_reset_out));

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  import clock_setup_pkg::*;
  logic clk_sys_in;
  logic reset_in;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [DATA_W-1:0] rdata;
  logic s_src, i_src, o_src, s_clk, i_clk, o_clk;
  logic s_v, i_v, o_v, s_r, i_r, o_r;
  logic app_reset_out;
  logic [LED_COUNT-1:0] led_out;
  logic [2:0] stall;
  logic [31:0] seed;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] hb0;
  logic [CTRL_W-1:0] cfg;
  logic [2:0] src0;
  logic [2:0] src1;
  int n_fail;
  int check_count;
  int cycles;

  fifo_clock_domain_setup i_fifo_clock_domain_setup (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
    .shared_clock_source_out(s_src), .input_clock_source_out(i_src),
    .output_clock_source_out(o_src), .shared_fifo_clock_in(s_clk),
    .input_fifo_clock_in(i_clk), .output_fifo_clock_in(o_clk),
    .shared_clock_valid_out(s_v), .input_clock_valid_out(i_v), .output_clock_valid_out(o_v),
    .shared_fifo_reset_out(s_r), .input_fifo_reset_out(i_r), .output_fifo_reset_out(o_r),
    .app_reset_out(app_reset_out), .led_out(led_out));

  clock_return_model i_clock_return_model (
    .shared_src_in(s_src), .input_src_in(i_src), .output_src_in(o_src), .stall_in(stall),
    .shared_clk_out(s_clk), .input_clk_out(i_clk), .output_clk_out(o_clk));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Settled valid vector {output, input, shared} for a mode
  function automatic logic [2:0] exp_valid(input logic [CTRL_W-1:0] c);
    return c[CTRL_COMMON_BIT] ? 3'h1 : 3'h6;
  endfunction : exp_valid

  // Paths {shared, input, output} that carry the halved oscillator in a mode
  function automatic logic [2:0] exp_src(input logic [CTRL_W-1:0] c);
    return c[CTRL_COMMON_BIT] ? 3'h4 : 3'h3;
  endfunction : exp_src

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Bounded wait: a loop that never locks must not hang the run
  task automatic wait_valid(input logic [2:0] exp, input int limit);
    for (int i = 0; i < limit && {o_v, i_v, s_v} !== exp; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk(DATA_W'({o_v, i_v, s_v}), DATA_W'(exp));
  endtask : wait_valid

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    reset_in = 1'b1;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    stall = 3'h0;
    seed = 32'h0001571D;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    #1;
    chk(DATA_W'({s_r, i_r, o_r, s_v, i_v, o_v}), 32'h38);
    rd(OFF_CTRL, rdat);
    chk(rdat, DATA_W'(CTRL_RESET));
    seed = xorshift(seed);
    wr(4'hC, seed);
    rd(4'hC, rdat);
    chk(rdat, 32'h0);
    rd(OFF_CTRL, rdat);
    chk(rdat, DATA_W'(CTRL_RESET));
    // Halved oscillator is 50 MHz, so every range bit stays low
    for (int k = 0; k < 4; k++) begin
      cfg = k[0] ? 5'h10 : 5'h11;
      seed = xorshift(seed);
      wr(OFF_CTRL, {seed[31:CTRL_W], cfg});
      rd(OFF_CTRL, rdat);
      chk(rdat, DATA_W'(cfg));
      wait_valid(exp_valid(cfg), 100);
      rd(OFF_STATUS, rdat);
      chk(rdat, DATA_W'({exp_valid(cfg), exp_valid(cfg)}));
      // A halved source flips every cycle on the paths in use, others stay low
      @(posedge clk_sys_in);
      #1;
      src0 = {s_src, i_src, o_src};
      @(posedge clk_sys_in);
      #1;
      src1 = {s_src, i_src, o_src};
      chk(DATA_W'({src0 ^ src1, src0 | src1}), DATA_W'({2{exp_src(cfg)}}));
    end
    stall <= 3'h2;
    wait_valid(3'h4, 400);
    chk(DATA_W'({i_r, o_r}), 32'h2);
    stall <= 3'h0;
    wait_valid(3'h6, 100);
    rd(OFF_HEARTBEAT, hb0);
    rd(OFF_HEARTBEAT, rdat);
    chk(rdat - hb0, 32'h2);
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk(DATA_W'({app_reset_out, led_out[LED_HEARTBEAT], s_r}), 32'h5);
    @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(OFF_HEARTBEAT, rdat);
    chk(DATA_W'(rdat < 32'h4), 32'h1);
    rd(OFF_CTRL, rdat);
    chk(rdat, DATA_W'(CTRL_RESET));
    end_sim();
  end
endmodule : tb
